//--- src/wdt_pkg.sv
// watchdog and reset control: shared constants
// assumes a 50 MHz system clock and a slow rc clock enable input
package wdt_pkg;
   // register byte addresses on the lite bus
   localparam logic [3:0] ctrl_addr      = 4'h0; // watchdog_control
   localparam logic [3:0] flags_addr     = 4'h4; // sleep_mode_reset_flags
   localparam logic [3:0] status_addr    = 4'h8; // expiry / sleep flags
   localparam logic [3:0] cmd_addr       = 4'hc; // clear / halt / sleep
   // control register layout
   localparam logic [7:0] ctrl_reset     = 8'h53;
   localparam logic [4:0] key_disable    = 5'h15; // 10101
   localparam logic [4:0] key_enable     = 5'h0a; // 01010
   localparam int         key_lsb        = 3;
   localparam int         key_flag_bit   = 0;
   localparam int         idle_keep_bit  = 7;
   localparam logic [7:0] flags_wmask    = 8'h8f; // bits 6..4 read zero
   // counter
   localparam int         cnt_w          = 16;
   localparam int         period_base    = 8;
   localparam logic [1:0] debounce_ticks = 2'h2;
   // start-up delays, microseconds, and system clock rate
   localparam int         clk_mhz        = 50;
   localparam int         por_delay_us   = 50000;
   localparam int         pin_delay_us   = 16700;
   localparam int         por_cycles     = por_delay_us * clk_mhz;
   localparam int         pin_cycles     = pin_delay_us * clk_mhz;
   localparam int         dly_w          = 22;
endpackage

//--- src/wdt_startup_timer.sv
// start-up hold-off counter: run stays low for the loaded count
// assumes load is a one-cycle request with the count alongside
`timescale 1ns/1ns
module wdt_startup_timer
   import wdt_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             load,
   input  wire logic [dly_w-1:0] count,
   output logic                  run
);
   logic [dly_w-1:0] left_r; // cycles still to wait

   // count down, loading restarts the wait
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_r <= '0;
      end else if (load) begin
         left_r <= count;
      end else if (left_r != '0) begin
         left_r <= left_r - 1'b1;
      end
   end

   assign run = (left_r == '0) && !load;
endmodule

//--- src/watchdog_and_reset_control.sv
// watchdog timer with keyed enable, reset flags and start-up hold-off
// assumes low_speed_rc_osc_tick is a one-cycle enable per slow rc clock period,
// por_n is the power-on level and external_clear_pin_n synchronous
//
// Contract
// - counter advances only on slow rc ticks
// - period code selects two to eight-plus-code
// - key 10101 disables, 01010 enables, else reset
// - bad key resets after debounce, sets flag
// - key flag set by hardware, software clears only
// - running overflow gives full reset, expiry flag
// - sleeping overflow resets only pc and sp
// - key reset, pin, clear, halt clear count
// - clear and halt instructions clear counter by software
// - power-on presets ports high, pc zero
// - pin low resets device, pc to zero
// - pin reset keeps some registers unchanged
// - pin release holds off about 16.7 ms
// - power-on holds off about 50 ms
// - flag bits six to four read zero
// - halt with watchdog on keeps counting
// - halt with watchdog off stops counter
// - sleeping overflow sets expiry and sleep flags
`timescale 1ns/1ns
module watchdog_and_reset_control
   import wdt_pkg::*;
#(
   parameter int por_delay  = por_cycles, // shorten for simulation
   parameter int pin_delay  = pin_cycles
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        por_n,
   input  wire logic        low_speed_rc_osc_tick,
   input  wire logic        external_clear_pin_n,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             full_reset,
   output logic             pc_sp_reset,
   output logic             port_preset,
   output logic             cpu_run
);
   logic [7:0]       ctrl_r;      // watchdog_control
   logic [7:0]       flags_r;     // sleep_mode_reset_flags
   logic             expiry_r;    // expiry_flag
   logic             sleep_r;     // sleep_entered_flag
   logic [cnt_w-1:0] cnt_r;       // watchdog count
   logic [1:0]       deb_r;       // key debounce ticks
   logic             full_r;      // full device reset pulse
   logic             pcsp_r;      // pc and sp only reset pulse
   logic             port_r;      // power-on port preset pulse
   logic             pin_q_r;     // previous pin level
   logic             por_q_r;     // previous power level
   logic             aw_r, w_r;   // captured write halves
   logic [3:0]       awa_r;       // captured write address
   logic [31:0]      wd_r;        // captured write data
   logic [3:0]       ws_r;        // captured strobes
   logic             bv_r, rv_r;  // answers pending
   logic [1:0]       bresp_r, rresp_r;
   logic [31:0]      rd_r;
   logic             wr_go;       // write performed this cycle
   logic             ok_addr;     // write address mapped
   logic             key_bad, wdt_on, wdt_off, ovf, clr_insn, halt_insn;
   logic             pin_low, pin_rise, por_rise, st_load;
   logic [dly_w-1:0] st_count;

   // mapped address check, used by read and write paths
   function automatic logic mapped(input logic [3:0] a);
      return a == ctrl_addr || a == flags_addr ||
             a == status_addr || a == cmd_addr;
   endfunction

   // overflow threshold reached for a period code
   function automatic logic at_limit(input logic [cnt_w-1:0] c,
                                     input logic [2:0] code);
      return c[period_base + code] == 1'b1;
   endfunction

   assign key_bad = ctrl_r[7:key_lsb] != key_enable &&
                    ctrl_r[7:key_lsb] != key_disable;
   assign wdt_on  = ctrl_r[7:key_lsb] == key_enable;
   assign wdt_off = ctrl_r[7:key_lsb] == key_disable;
   assign pin_low = !external_clear_pin_n;
   assign ovf     = wdt_on && low_speed_rc_osc_tick &&
                    at_limit(cnt_r + 1'b1, ctrl_r[2:0]);

   // write channel: address and data accepted in either order
   assign s_axi_awready = !aw_r && !bv_r;
   assign s_axi_wready  = !w_r && !bv_r;
   assign wr_go   = aw_r && w_r && !bv_r;
   assign ok_addr = mapped(awa_r);
   // command word: bit0 clear instruction, bit1 halt, only when mapped
   assign clr_insn  = wr_go && awa_r == cmd_addr && ws_r[0] &&
                      wd_r[0];
   assign halt_insn = wr_go && awa_r == cmd_addr && ws_r[0] && wd_r[1];

   // write address/data capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_r    <= 1'b0;
         w_r     <= 1'b0;
         awa_r   <= 4'h0;
         wd_r    <= 32'h0;
         ws_r    <= 4'h0;
         bv_r    <= 1'b0;
         bresp_r <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_r  <= 1'b1;
            awa_r <= s_axi_awaddr[3:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_r  <= 1'b1;
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_r    <= 1'b0;
            w_r     <= 1'b0;
            bv_r    <= 1'b1;
            bresp_r <= ok_addr ? 2'h0 : 2'h3; // unmapped: decode error
         end else if (bv_r && s_axi_bready) begin
            bv_r <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp  = bresp_r;

   // read channel, one cycle answer from a register
   assign s_axi_arready = !rv_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rv_r    <= 1'b0;
         rd_r    <= 32'h0;
         rresp_r <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rv_r    <= 1'b1;
         rresp_r <= mapped(s_axi_araddr[3:0]) ? 2'h0 : 2'h3;
         unique case (s_axi_araddr[3:0])
            ctrl_addr:   rd_r <= {24'h0, ctrl_r};
            flags_addr:  rd_r <= {24'h0, flags_r & flags_wmask};
            status_addr: rd_r <= {30'h0, sleep_r, expiry_r};
            default:     rd_r <= 32'h0; // command and unmapped read 0
         endcase
      end else if (rv_r && s_axi_rready) begin
         rv_r <= 1'b0;
      end
   end
   assign s_axi_rvalid = rv_r;
   assign s_axi_rdata  = rd_r;
   assign s_axi_rresp  = rresp_r;

   // control register; full resets and power-on both restore it
   always_ff @(posedge aclk) begin
      if (!aresetn || port_r || full_r) begin
         ctrl_r <= ctrl_reset;
      end else if (wr_go && awa_r == ctrl_addr && ws_r[0]) begin
         ctrl_r <= wd_r[7:0];
      end
   end

   // key debounce: bad key must persist three slow ticks
   always_ff @(posedge aclk) begin
      if (!aresetn || !key_bad) begin
         deb_r <= 2'h0;
      end else if (low_speed_rc_osc_tick && deb_r != debounce_ticks) begin
         deb_r <= deb_r + 1'b1;
      end
   end

   // watchdog count
   always_ff @(posedge aclk) begin
      if (!aresetn || wdt_off) begin
         cnt_r <= '0;
      end else if (key_bad || pin_low || clr_insn || halt_insn) begin
         cnt_r <= '0;
      end else if (ovf) begin
         cnt_r <= '0;
      end else if (wdt_on && low_speed_rc_osc_tick) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
   // halt with key enabled keeps counting from the next tick
   // halt with key disabled leaves the count held at zero

   // reset flags: set wins over a software clear
   always_ff @(posedge aclk) begin
      if (!aresetn || port_r) begin
         flags_r <= 8'h00;
      end else begin
         if (wr_go && awa_r == flags_addr && ws_r[0]) begin
            flags_r[idle_keep_bit] <= wd_r[idle_keep_bit];
            flags_r[3:0] <= flags_r[3:0] & wd_r[3:0];
         end
         if (key_bad && low_speed_rc_osc_tick && deb_r == debounce_ticks) begin
            flags_r[key_flag_bit] <= 1'b1;
         end
      end
   end

   // expiry and sleep flags; pin reset leaves them alone
   always_ff @(posedge aclk) begin
      if (!aresetn || port_r) begin
         expiry_r <= 1'b0;
         sleep_r  <= 1'b0;
      end else if (ovf) begin
         expiry_r <= 1'b1;
      end else if (halt_insn) begin
         sleep_r  <= 1'b1;
         expiry_r <= 1'b0;
      end else if (clr_insn) begin
         sleep_r  <= 1'b0;
      end
   end
   // sleeping overflow keeps sleep_r at one

   // reset pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_r  <= 1'b0;
         pcsp_r  <= 1'b0;
         port_r  <= 1'b0;
         pin_q_r <= 1'b1;
         por_q_r <= 1'b0;
      end else begin
         pin_q_r <= external_clear_pin_n;
         por_q_r <= por_n;
         port_r  <= por_n && !por_q_r;
         full_r  <= (ovf && !sleep_r) || pin_low ||
                    (key_bad && low_speed_rc_osc_tick &&
                     deb_r == debounce_ticks);
         pcsp_r  <= ovf && sleep_r;
      end
   end
   assign full_reset  = full_r || !por_n;
   assign pc_sp_reset = pcsp_r;
   assign port_preset = port_r;

   // start-up hold-off after power or pin release
   assign pin_rise = external_clear_pin_n && !pin_q_r;
   assign por_rise = por_n && !por_q_r;
   assign st_load  = por_rise || pin_rise || full_r;
   assign st_count = por_rise ? dly_w'(por_delay)
                              : dly_w'(pin_delay);
   logic st_run;
   wdt_startup_timer u_st (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (st_load),
      .count   (st_count),
      .run     (st_run)
   );
   assign cpu_run = st_run && por_n && external_clear_pin_n;

   // overflow of an enabled counter raises expiry the next cycle
   chk_ovf_sets_expiry: assert property (@(posedge aclk)
      disable iff (!aresetn) ovf |=> expiry_r)
      else $error("overflow did not set expiry flag");
   chk_disable_holds_zero: assert property (@(posedge aclk)
      disable iff (!aresetn) wdt_off |=> cnt_r == '0)
      else $error("disabled watchdog counted");
   chk_flag_not_sw_set: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $rose(flags_r[key_flag_bit]) |-> $past(key_bad))
      else $error("key flag set without bad key");
   chk_sleep_ovf_pcsp: assert property (@(posedge aclk)
      disable iff (!aresetn) (ovf && sleep_r) |=> pcsp_r && !full_r)
      else $error("sleeping overflow gave wrong reset");
   chk_run_ovf_full: assert property (@(posedge aclk)
      disable iff (!aresetn) (ovf && !sleep_r) |=> full_r)
      else $error("running overflow gave no full reset");
   chk_clear_insn: assert property (@(posedge aclk)
      disable iff (!aresetn) clr_insn |=> cnt_r == '0)
      else $error("clear instruction left count");
   chk_pin_holds: assert property (@(posedge aclk)
      disable iff (!aresetn) pin_low |=> full_r && !cpu_run)
      else $error("pin low did not reset");
   chk_unused_bits: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (rv_r && $past(s_axi_araddr[3:0]) == flags_addr &&
       $rose(rv_r)) |-> rd_r[6:4] == 3'h0)
      else $error("unimplemented flag bits read nonzero");
endmodule

//--- dv/watchdog_and_reset_control_test.sv
// self-checking bench for the watchdog and reset control block
// assumes shortened hold-off counts and a slow tick every third cycle
`timescale 1ns/1ns
module watchdog_and_reset_control_test;
   import wdt_pkg::*;
   localparam int por_d = 20; // shortened power-on hold-off
   localparam int pin_d = 10; // shortened pin hold-off
   typedef struct packed {logic [3:0] a; logic [7:0] wd; logic [7:0] ex;} row_t;
   logic aclk = 0, aresetn = 0, por_n = 0, low_speed_rc_osc_tick = 0, pin_n = 1;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic [3:0]  wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic full_reset, pc_sp_reset, port_preset, cpu_run;
   logic [7:0]  rd;       // last read byte
   int err_total = 0, checks_done = 0;
   int fr_cnt = 0, ps_cnt = 0, pp_cnt = 0, f0, p0; // pulse tallies
   // plain register rows: write, read back, expect
   row_t rows [5] = '{'{ctrl_addr, 8'h50, 8'h50}, '{ctrl_addr, 8'h57, 8'h57},
      '{ctrl_addr, 8'haf, 8'haf}, '{flags_addr, 8'hf1, 8'h80},
      '{flags_addr, 8'h00, 8'h00}};
   always #10 aclk = ~aclk; // 50 MHz
   watchdog_and_reset_control #(.por_delay(por_d), .pin_delay(pin_d)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .low_speed_rc_osc_tick(low_speed_rc_osc_tick),
      .external_clear_pin_n(pin_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .full_reset(full_reset),
      .pc_sp_reset(pc_sp_reset), .port_preset(port_preset), .cpu_run(cpu_run));
   // tally reset pulses at mid-cycle, so reads at a rising edge never race
   always @(negedge aclk) begin
      if (full_reset === 1'b1) fr_cnt++;
      if (pc_sp_reset === 1'b1) ps_cnt++;
      if (port_preset === 1'b1) pp_cnt++;
   end
   // verdict and end of run
   task close_out;
      $display("checks_done %0d err_total %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks_done++;
      if (seen !== ex) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   // lite write: handshakes judged at negedge, valid dropped after the edge
   task axi_write(input logic [3:0] a, input logic [7:0] d);
      int n;
      logic awh, wh, bh;
      bh = 0;
      @(posedge aclk);
      awaddr <= {28'h0, a}; awvalid <= 1; wdata <= {24'h0, d};
      wstrb <= 4'h1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50 && !bh; n++) begin
         @(negedge aclk);
         awh = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (awh) awvalid <= 0;
         if (wh) wvalid <= 0;
         if (bh) bready <= 0;
      end
      if (!bh) begin
         err_total++;
         close_out();
      end
   endtask
   task axi_read(input logic [3:0] a);
      int n;
      logic arh, rh;
      rh = 0;
      @(posedge aclk);
      araddr <= {28'h0, a}; arvalid <= 1; rready <= 1;
      for (n = 0; n < 50 && !rh; n++) begin
         @(negedge aclk);
         arh = arvalid & arready;
         rh = rvalid;
         rd = rdata[7:0];
         resp = rresp;
         @(posedge aclk);
         if (arh) arvalid <= 0;
         if (rh) rready <= 0;
      end
      if (!rh) begin
         err_total++;
         close_out();
      end
   endtask
   // slow rc ticks, one enable pulse each three cycles
   task ticks(input int n);
      repeat (n) begin
         @(posedge aclk) low_speed_rc_osc_tick <= 1;
         @(posedge aclk) low_speed_rc_osc_tick <= 0;
         @(posedge aclk);
      end
   endtask
   initial begin
      repeat (100000) @(posedge aclk);
      err_total++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk) por_n <= 1; // power arrives
      repeat (por_d - 2) @(posedge aclk);
      chk("cpu_run held", cpu_run, 0);
      repeat (5) @(posedge aclk);
      chk("cpu_run up", cpu_run, 1);
      chk("port preset", pp_cnt, 1);
      axi_read(ctrl_addr); chk("ctrl reset", rd, ctrl_reset);
      axi_read(flags_addr); chk("flags reset", rd, 8'h00);
      axi_read(4'h2); // unaligned offset, no register behind it
      chk("unmapped data", rd, 8'h00);
      chk("unmapped resp", resp, 2'h3);
      axi_read(status_addr); chk("status reset", rd, 8'h00);
      chk("read resp", resp, 2'h0);
      // table of plain register cases
      foreach (rows[i]) begin
         axi_write(rows[i].a, rows[i].wd);
         chk("write resp", resp, 2'h0);
         axi_read(rows[i].a);
         chk("row readback", rd, rows[i].ex);
      end
      // corrupted key: reset after debounce, flag latched
      f0 = fr_cnt;
      axi_write(ctrl_addr, 8'h03);
      ticks(1); chk("no early reset", fr_cnt - f0, 0);
      ticks(2); chk("key reset", fr_cnt - f0, 1);
      axi_read(flags_addr); chk("key flag", rd, 8'h01);
      axi_read(ctrl_addr); chk("ctrl restored", rd, ctrl_reset);
      axi_write(flags_addr, 8'h80);
      axi_read(flags_addr); chk("flag cleared", rd, 8'h80);
      // shortest period, cleared by the clear command midway
      axi_write(ctrl_addr, 8'h50);
      axi_write(cmd_addr, 8'h01);
      f0 = fr_cnt;
      ticks(200); axi_write(cmd_addr, 8'h01);
      ticks(255); chk("no overflow", fr_cnt - f0, 0);
      ticks(1); chk("overflow reset", fr_cnt - f0, 1);
      axi_read(status_addr); chk("expiry flag", rd, 8'h01);
      axi_read(ctrl_addr); chk("ctrl after wdt", rd, ctrl_reset);
      // period code one doubles the timeout
      axi_write(ctrl_addr, 8'h51);
      axi_write(cmd_addr, 8'h01);
      f0 = fr_cnt;
      ticks(511);
      chk("code one early", fr_cnt - f0, 0);
      ticks(1);
      chk("code one overflow", fr_cnt - f0, 1);
      // overflow while halted resets only pc and sp
      axi_write(ctrl_addr, 8'h50);
      axi_write(cmd_addr, 8'h02);
      f0 = fr_cnt; p0 = ps_cnt;
      ticks(255); chk("halt keeps count", ps_cnt - p0, 0);
      ticks(1); chk("pc sp reset", ps_cnt - p0, 1);
      chk("no full reset", fr_cnt - f0, 0);
      axi_read(status_addr); chk("sleep flags", rd, 8'h03);
      // disabled watchdog never gives a full reset while halted
      axi_write(ctrl_addr, 8'ha8);
      axi_write(cmd_addr, 8'h02);
      f0 = fr_cnt;
      ticks(300); chk("disabled quiet", fr_cnt - f0, 0);
      // pin pulse clears the count and restarts the hold-off
      axi_write(ctrl_addr, 8'h50);
      axi_write(cmd_addr, 8'h01);
      ticks(200);
      f0 = fr_cnt;
      @(posedge aclk) pin_n <= 0;
      repeat (4) @(posedge aclk);
      chk("pin reset", fr_cnt - f0 > 0, 1);
      chk("pin stops cpu", cpu_run, 0);
      pin_n <= 1;
      repeat (pin_d - 2) @(posedge aclk);
      chk("pin hold-off", cpu_run, 0);
      repeat (5) @(posedge aclk);
      chk("pin run", cpu_run, 1);
      axi_read(flags_addr); chk("flags kept", rd, 8'h80);
      // pin restored the long period; go short so a stale count would fire
      axi_write(ctrl_addr, 8'h50);
      f0 = fr_cnt;
      ticks(200); chk("pin cleared count", fr_cnt - f0, 0);
      close_out();
   end
endmodule
